/* File: zq_odt_ctrl.sv */
// zq_odt_ctrl: zq command handling and on-die termination state for one device
// assumes commands, odt and mode fields arrive on LINK_CK; calibration runs on CLOCK
`timescale 1ns/1ps
module zq_odt_ctrl
  import zq_odt_pkg::*;
#(
  parameter int unsigned ZQINIT_CYC = ZQINIT_CYC_DEF,
  parameter int unsigned ZQOPER_CYC = ZQOPER_CYC_DEF,
  parameter int unsigned ZQCS_CYC = ZQCS_CYC_DEF
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic LINK_CK,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_CODE,
  input wire logic CMD_BC4,
  input wire logic ODT_IN,
  input wire logic [2:0] RTT_NOM_FLD,
  input wire logic [1:0] RTT_WR_FLD,
  input wire logic [2:0] RTT_PARK_FLD,
  input wire logic DLL_ON,
  input wire logic [4:0] CWL,
  input wire logic [4:0] AL,
  input wire logic [2:0] PL,
  input wire logic [4:0] CL,
  input wire logic PREAMBLE_2T,
  input wire logic WR_CRC_EN,
  output logic ZQ_BUSY,
  output logic ZQ_CURRENT_EN,
  output logic ZQ_IO_UPDATE,
  output logic ZQ_FIRST_DONE,
  output logic [2:0] TERM_MODE,
  output logic [2:0] RTT_CODE,
  output logic IN_SELF_REFRESH,
  output logic ODT_IGNORED
);

  // ----------------------------------------------------------------
  // reset into the link domain
  // ----------------------------------------------------------------
  logic rs1_q, rs2_q, rs3_q, rst_l_q;

  always_ff @(posedge LINK_CK) begin
    rs1_q <= SRST;
    rs2_q <= rs1_q;
    rs3_q <= rs2_q;
    rst_l_q <= (rs2_q == rs3_q) ? rs3_q : rst_l_q;
  end

  // ----------------------------------------------------------------
  // link side: commands, self refresh, zq requests
  // ----------------------------------------------------------------
  zq_if zq();

  lstate_t lst_q, lst_d;
  logic zql_t_q, zql_t_d, zqs_t_q, zqs_t_d;
  logic pend_q, pend_d;
  logic bz1_q, bz2_q, bz3_q, busy_l_q, busy_l_d;
  logic sr, quiet, is_zql, is_zqs, is_rd, is_wr;

  always_comb begin
    sr = (lst_q == L_SREF);
    quiet = pend_q | busy_l_q;
    is_zql = CMD_VALID && (CMD_CODE == CMD_ZQCL) && !sr && !quiet;
    is_zqs = CMD_VALID && (CMD_CODE == CMD_ZQCS) && !sr && !quiet;
    is_rd = CMD_VALID && (CMD_CODE == CMD_READ) && !sr;
    is_wr = CMD_VALID && (CMD_CODE == CMD_WRITE) && !sr;
    lst_d = lst_q;
    unique case (lst_q)
      L_RUN: begin
        if (CMD_VALID && CMD_CODE == CMD_SRE) lst_d = L_SREF;
      end
      L_SREF: begin
        // exit only leaves self refresh; no calibration is kicked off here
        if (CMD_VALID && CMD_CODE == CMD_SRX) lst_d = L_RUN; // [R7]
      end
      default: lst_d = L_RUN;
    endcase
    // a second zq command inside a window is dropped, the channel must be quiet
    zql_t_d = zql_t_q ^ is_zql; // [R4]
    zqs_t_d = zqs_t_q ^ is_zqs;
    // pending covers the gap until busy comes back across the crossing
    pend_d = is_zql | is_zqs | (pend_q & ~busy_l_q);
    busy_l_d = (bz2_q == bz3_q) ? bz3_q : busy_l_q;
  end

  always_ff @(posedge LINK_CK) begin
    bz1_q <= zq.busy;
    bz2_q <= bz1_q;
    bz3_q <= bz2_q;
  end

  always_ff @(posedge LINK_CK) begin
    if (rst_l_q) begin
      lst_q <= L_RUN;
      zql_t_q <= 1'b0;
      zqs_t_q <= 1'b0;
      pend_q <= 1'b0;
      busy_l_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      zql_t_q <= zql_t_d;
      zqs_t_q <= zqs_t_d;
      pend_q <= pend_d;
      busy_l_q <= busy_l_d;
    end
  end

  // ----------------------------------------------------------------
  // link side: read and write windows, odt latency
  // ----------------------------------------------------------------
  win_t rd_q, rd_d, wr_q, wr_d;
  logic [6:0] wl, rl, xv, odt_lat;
  logic [4:0] y, rd_len, wr_len;
  logic rd_bc4_q, wr_bc4_q;
  logic odt_dly;

  always_comb begin
    wl = 7'({2'h0, CWL} + {2'h0, AL} + {4'h0, PL});
    rl = 7'({2'h0, CL} + {2'h0, AL} + {4'h0, PL});
    xv = PREAMBLE_2T ? X_2T : X_1T;
    y = WR_CRC_EN ? CRC_Y : 5'h00;
    rd_len = 5'((rd_bc4_q ? BC4_HALF : BL8_HALF) + xv[4:0] + y);
    wr_len = 5'((wr_bc4_q ? BC4_HALF : BL8_HALF) + xv[4:0] + y);
    odt_lat = lat_sub(wl, PREAMBLE_2T ? ODT_SUB_2T : ODT_SUB_1T); // [R20] [R21]
    rd_d = win_step(rd_q, is_rd, lat_sub(rl, xv), rd_len); // [R17]
    wr_d = win_step(wr_q, is_wr, lat_sub(wl, xv), wr_len); // [R14]
  end

  always_ff @(posedge LINK_CK) begin
    if (rst_l_q) begin
      rd_q <= WIN_RST;
      wr_q <= WIN_RST;
      rd_bc4_q <= 1'b0;
      wr_bc4_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      rd_bc4_q <= is_rd ? CMD_BC4 : rd_bc4_q;
      wr_bc4_q <= is_wr ? CMD_BC4 : wr_bc4_q;
    end
  end

  odt_latency u_odt_lat (
    .clk(LINK_CK),
    .rst(rst_l_q),
    .odt_in(ODT_IN),
    .sync_mode(DLL_ON), // [R19] [R24]
    .lat(odt_lat),
    .odt_dly(odt_dly)
  );

  // ----------------------------------------------------------------
  // link side: termination priority
  // ----------------------------------------------------------------
  term_t term_q, term_d;
  logic [2:0] code_q, code_d;
  logic ign_q, ign_d, sref_q;
  logic nom_en, wr_en, park_en, mode_en, nom_on, rd_on, wr_on;

  always_comb begin
    nom_en = |RTT_NOM_FLD;
    wr_en = |RTT_WR_FLD;
    park_en = |RTT_PARK_FLD;
    mode_en = nom_en | wr_en | park_en; // [R13]
    nom_on = odt_dly && nom_en && !sr; // [R12]
    rd_on = (rd_d.len != 5'h00);
    wr_on = (wr_d.len != 5'h00);
    ign_d = sr | ~nom_en; // [R12]
    term_d = T_OFF;
    code_d = 3'h0;
    if (sr) begin
      term_d = T_OFF; // [R11]
    end else if (rd_on) begin
      term_d = T_DRIVE; // [R17] [R18]
    end else if (quiet) begin
      term_d = park_en ? T_PARK : T_OFF; // [R10]
      code_d = RTT_PARK_FLD;
    end else if (!mode_en) begin
      term_d = T_OFF; // [R13]
    end else if (wr_on && wr_en) begin
      term_d = T_WR; // [R14] [R18]
      code_d = {1'b0, RTT_WR_FLD}; // [R23]
    end else if (nom_on) begin
      term_d = T_NOM; // [R15]
      code_d = RTT_NOM_FLD; // [R23]
    end else if (park_en) begin
      term_d = T_PARK; // [R16]
      code_d = RTT_PARK_FLD; // [R23]
    end
  end

  always_ff @(posedge LINK_CK) begin
    if (rst_l_q) begin
      term_q <= T_OFF;
      code_q <= 3'h0;
      ign_q <= 1'b1;
      sref_q <= 1'b0;
    end else begin
      term_q <= term_d;
      code_q <= code_d;
      ign_q <= ign_d;
      sref_q <= (lst_d == L_SREF);
    end
  end

  assign TERM_MODE = term_q;
  assign RTT_CODE = code_q;
  assign ODT_IGNORED = ign_q;
  assign IN_SELF_REFRESH = sref_q;

  // ----------------------------------------------------------------
  // core side: zq request crossing and engine
  // ----------------------------------------------------------------
  logic zl1_q, zl2_q, zl3_q, zs1_q, zs2_q, zs3_q;
  logic seen_l_q, seen_l_d, seen_s_q, seen_s_d;
  logic st_l_q, st_l_d, st_s_q, st_s_d;

  always_ff @(posedge CLOCK) begin
    zl1_q <= zql_t_q;
    zl2_q <= zl1_q;
    zl3_q <= zl2_q;
    zs1_q <= zqs_t_q;
    zs2_q <= zs1_q;
    zs3_q <= zs2_q;
  end

  always_comb begin
    st_l_d = (zl2_q == zl3_q) && (zl3_q != seen_l_q);
    st_s_d = (zs2_q == zs3_q) && (zs3_q != seen_s_q);
    seen_l_d = st_l_d ? zl3_q : seen_l_q;
    seen_s_d = st_s_d ? zs3_q : seen_s_q;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      seen_l_q <= 1'b0;
      seen_s_q <= 1'b0;
      st_l_q <= 1'b0;
      st_s_q <= 1'b0;
    end else begin
      seen_l_q <= seen_l_d;
      seen_s_q <= seen_s_d;
      st_l_q <= st_l_d;
      st_s_q <= st_s_d;
    end
  end

  assign zq.start_long = st_l_q;
  assign zq.start_short = st_s_q;

  zq_cal_engine #(
    .INIT_CYC(ZQINIT_CYC),
    .OPER_CYC(ZQOPER_CYC),
    .CS_CYC(ZQCS_CYC)
  ) u_engine (
    .clk(CLOCK),
    .rst(SRST),
    .zq(zq)
  );

  assign ZQ_BUSY = zq.busy;
  assign ZQ_CURRENT_EN = zq.cur_en;
  assign ZQ_IO_UPDATE = zq.io_update;
  assign ZQ_FIRST_DONE = zq.first_done;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sref_off;
    @(posedge LINK_CK) disable iff (rst_l_q)
    sr |=> (term_q == T_OFF) && (code_q == 3'h0);
  endproperty
  a_sref_off: assert property (p_sref_off) else $error("termination on in self refresh"); // [R11]

  property p_rd_drive;
    @(posedge LINK_CK) disable iff (rst_l_q)
    (rd_q.len != 5'h00) && !$past(sr) |-> (term_q == T_DRIVE);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read did not disable odt"); // [R17]

  property p_quiet_park;
    @(posedge LINK_CK) disable iff (rst_l_q)
    (quiet && !sr && !rd_on) |=> (term_q != T_NOM) && (code_q == $past(RTT_PARK_FLD));
  endproperty
  a_quiet_park: assert property (p_quiet_park) else $error("not parked during zq"); // [R10]

  property p_wr_prio;
    @(posedge LINK_CK) disable iff (rst_l_q)
    (wr_on && wr_en && !sr && !rd_on && !quiet) |=> (term_q == T_WR);
  endproperty
  a_wr_prio: assert property (p_wr_prio) else $error("write term not applied"); // [R14] [R18]

  property p_nom;
    @(posedge LINK_CK) disable iff (rst_l_q)
    (nom_on && !rd_on && !quiet && !(wr_on && wr_en)) |=> (term_q == T_NOM);
  endproperty
  a_nom: assert property (p_nom) else $error("nominal term not applied"); // [R15]

  property p_ignore;
    @(posedge LINK_CK) disable iff (rst_l_q)
    ign_q |-> (term_q != T_NOM);
  endproperty
  a_ignore: assert property (p_ignore) else $error("odt used while ignored"); // [R12]

  property p_disabled;
    @(posedge LINK_CK) disable iff (rst_l_q)
    (!mode_en && !rd_on) |=> (term_q == T_OFF);
  endproperty
  a_disabled: assert property (p_disabled) else $error("term on with fields zero"); // [R13]

  property p_srx_quiet;
    @(posedge LINK_CK) disable iff (rst_l_q)
    (sr && !quiet && CMD_VALID && CMD_CODE == CMD_SRX) |=>
      !pend_q && $stable(zql_t_q) && $stable(zqs_t_q);
  endproperty
  a_srx_quiet: assert property (p_srx_quiet) else $error("calibration on sr exit"); // [R7]

  c_sref: cover property (@(posedge LINK_CK) disable iff (rst_l_q) sr ##1 !sr);
  c_rd_wr: cover property (@(posedge LINK_CK) disable iff (rst_l_q)
    (term_q == T_WR) ##[1:40] (term_q == T_DRIVE));

endmodule : zq_odt_ctrl

/* File: zq_odt_pkg.sv */
// zq_odt_pkg: shared types, constants and helpers for zq calibration and odt control
// assumes mode-register fields and latency settings are held steady while in use
// Notes on behaviour
// R1: long calibration runs the engine, then pushes results to driver and termination
// R2: first long calibration after reset gets init window, later ones the oper window
// R3: short calibration finishes inside its window, correction done within 128 cycles
// R4: controller keeps the channel quiet during any calibration window
// R5: calibration current path is switched off once calibration completes
// R6: controller precharges all banks and waits precharge time before calibration
// R7: self refresh exit never starts calibration; only an explicit command does
// R8: controller keeps calibration windows of devices sharing a resistor apart
// R9: controller keeps clock enable high throughout calibration
// R10: odt held low during calibration; device keeps parked termination
// R11: self refresh entry forces termination off, high impedance, whatever the fields
// R12: odt input ignored in self refresh or when nominal field is zero
// R13: termination enabled when any of nominal, write or park fields nonzero
// R14: rank being written applies write termination whatever the odt level
// R15: odt seen high gives nominal termination unless nominal is disabled
// R16: parked value enabled and odt low gives parked termination
// R17: read turns termination off from RL-X for BL/2+X+Y cycles
// R18: priority is read disable, write, nominal, then parked termination
// R19: synchronous odt timing whenever the dll is on
// R20: nominal on and off latency is WL-2 after odt sampling
// R21: with two-cycle preamble both odt latencies are WL-3
// R22: controller holds odt high at least the burst-dependent hold time
// R23: write, nominal and park values come from their own mode fields
// R24: dll off selects asynchronous odt, with no latency applied
// R25: a flag remembers whether the first long calibration has been done
package zq_odt_pkg;

  // ----------------------------------------------------------------
  // commands, states and termination modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ZQCL = 3'h1,
    CMD_ZQCS = 3'h2,
    CMD_READ = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_SRE = 3'h5,
    CMD_SRX = 3'h6
  } cmd_t;

  typedef enum logic [2:0] {
    T_OFF = 3'h0,
    T_PARK = 3'h1,
    T_NOM = 3'h2,
    T_WR = 3'h3,
    T_DRIVE = 3'h4
  } term_t;

  typedef enum logic [1:0] {
    L_RUN = 2'h1,
    L_SREF = 2'h2
  } lstate_t;

  typedef enum logic [2:0] {
    E_IDLE = 3'h1,
    E_CAL = 3'h2,
    E_XFER = 3'h4
  } estate_t;

  // ----------------------------------------------------------------
  // counts and offsets
  // ----------------------------------------------------------------
  localparam int unsigned ZQINIT_CYC_DEF = 1024;
  localparam int unsigned ZQOPER_CYC_DEF = 512;
  localparam int unsigned ZQCS_CYC_DEF = 128;
  localparam int unsigned ZQCORR_CYC = 128;
  localparam logic [6:0] X_1T = 7'h02;
  localparam logic [6:0] X_2T = 7'h03;
  localparam logic [6:0] ODT_SUB_1T = 7'h02;
  localparam logic [6:0] ODT_SUB_2T = 7'h03;
  localparam logic [4:0] BL8_HALF = 5'h04;
  localparam logic [4:0] BC4_HALF = 5'h02;
  localparam logic [4:0] CRC_Y = 5'h01;
  localparam int unsigned ODT_DEPTH = 64;
  localparam logic [6:0] ODT_DEPTH_L = 7'h40;

  typedef struct packed {
    logic run;
    logic [6:0] dly;
    logic [4:0] len;
  } win_t;

  localparam win_t WIN_RST = '0;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // latency minus offset, never below one cycle
  function automatic logic [6:0] lat_sub(input logic [6:0] a, input logic [6:0] b);
    return (a > b) ? 7'(a - b) : 7'h01;
  endfunction : lat_sub

  // delayed window: starts dly cycles after start, then stays len cycles
  function automatic win_t win_step(input win_t w, input logic start,
                                    input logic [6:0] dly, input logic [4:0] len);
    win_t n;
    n = w;
    n.len = (w.len != 5'h00) ? 5'(w.len - 5'h01) : 5'h00;
    if (start) begin
      n.run = 1'b1;
      n.dly = dly;
    end else if (w.run) begin
      if (w.dly <= 7'h01) begin
        n.run = 1'b0;
        n.len = len;
      end else begin
        n.dly = 7'(w.dly - 7'h01);
      end
    end
    return n;
  endfunction : win_step

endpackage : zq_odt_pkg

/* File: zq_if.sv */
// zq_if: request and status signals between the control core and the calibration engine
// assumes both ends sit on the core clock
`timescale 1ns/1ps
interface zq_if;
  logic start_long;
  logic start_short;
  logic busy;
  logic io_update;
  logic cur_en;
  logic first_done;

  modport ctrl(
    output start_long,
    output start_short,
    input busy,
    input io_update,
    input cur_en,
    input first_done
  );

  modport engine(
    input start_long,
    input start_short,
    output busy,
    output io_update,
    output cur_en,
    output first_done
  );
endinterface : zq_if

/* File: zq_cal_engine.sv */
// zq_cal_engine: calibration window timing, io update pulse and current path control
// assumes one-cycle start pulses on the core clock; starts while busy are dropped
`timescale 1ns/1ps
module zq_cal_engine
  import zq_odt_pkg::*;
#(
  parameter int unsigned INIT_CYC = ZQINIT_CYC_DEF,
  parameter int unsigned OPER_CYC = ZQOPER_CYC_DEF,
  parameter int unsigned CS_CYC = ZQCS_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  zq_if.engine zq
);
  // windows count busy cycles: load value is window minus the transfer cycle and one
  localparam int unsigned CS_EFF = (CS_CYC < ZQCORR_CYC) ? CS_CYC : ZQCORR_CYC;
  localparam logic [15:0] INIT_LD = 16'(INIT_CYC - 2);
  localparam logic [15:0] OPER_LD = 16'(OPER_CYC - 2);
  localparam logic [15:0] CS_LD = 16'(CS_EFF - 2);

  estate_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic upd_q, upd_d;
  logic cur_q, cur_d;
  logic first_q, first_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    cur_d = cur_q;
    first_d = first_q;
    upd_d = 1'b0;
    unique case (st_q)
      E_IDLE: begin
        if (zq.start_long) begin
          st_d = E_CAL; // [R1]
          cnt_d = first_q ? OPER_LD : INIT_LD; // [R2]
          busy_d = 1'b1;
          cur_d = 1'b1;
          first_d = 1'b1; // [R25]
        end else if (zq.start_short) begin
          st_d = E_CAL;
          cnt_d = CS_LD; // [R3]
          busy_d = 1'b1;
          cur_d = 1'b1;
        end
      end
      E_CAL: begin
        if (cnt_q == 16'h0000) begin
          st_d = E_XFER;
          upd_d = 1'b1; // [R1]
        end else begin
          cnt_d = 16'(cnt_q - 16'h0001);
        end
      end
      E_XFER: begin
        st_d = E_IDLE;
        busy_d = 1'b0;
        cur_d = 1'b0; // [R5]
      end
      default: st_d = E_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= E_IDLE;
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      upd_q <= 1'b0;
      cur_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      upd_q <= upd_d;
      cur_q <= cur_d;
      first_q <= first_d;
    end
  end

  assign zq.busy = busy_q;
  assign zq.io_update = upd_q;
  assign zq.cur_en = cur_q;
  assign zq.first_done = first_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int CS_BOUND = 128;

  property p_long_start;
    @(posedge clk) disable iff (rst)
    (st_q == E_IDLE && zq.start_long) |=> (busy_q && cur_q) ##1 busy_q;
  endproperty
  a_long_start: assert property (p_long_start) else $error("long cal did not start"); // [R1]

  property p_first_win;
    @(posedge clk) disable iff (rst)
    (st_q == E_IDLE && zq.start_long) |=> (cnt_q == ($past(first_q) ? OPER_LD : INIT_LD));
  endproperty
  a_first_win: assert property (p_first_win) else $error("wrong long cal window"); // [R2] [R25]

  property p_short_done;
    @(posedge clk) disable iff (rst)
    (st_q == E_IDLE && zq.start_short && !zq.start_long) |-> ##[1:CS_BOUND] upd_q;
  endproperty
  a_short_done: assert property (p_short_done) else $error("short cal too long"); // [R3]

  property p_cur_off;
    @(posedge clk) disable iff (rst)
    upd_q |-> busy_q ##1 (!cur_q && !busy_q);
  endproperty
  a_cur_off: assert property (p_cur_off) else $error("zq current left on"); // [R5]

  c_long: cover property (@(posedge clk) disable iff (rst)
    (st_q == E_IDLE && zq.start_long) ##[1:1000] upd_q);
  c_short: cover property (@(posedge clk) disable iff (rst)
    (st_q == E_IDLE && zq.start_short) ##[1:CS_BOUND] upd_q);

endmodule : zq_cal_engine

/* File: odt_latency.sv */
// odt_latency: delay line for the sampled odt input, synchronous or pass-through
// assumes odt_in is already on the link clock; the consumer register adds one cycle
`timescale 1ns/1ps
module odt_latency
  import zq_odt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic odt_in,
  input wire logic sync_mode,
  input wire logic [6:0] lat,
  output logic odt_dly
);
  logic [ODT_DEPTH-1:0] sh_q, sh_d;
  logic [5:0] tap;

  always_comb begin
    sh_d = {sh_q[ODT_DEPTH-2:0], odt_in};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

  // latencies past the line depth saturate at its last tap
  always_comb begin
    tap = (lat > ODT_DEPTH_L) ? 6'h3f : 6'(lat - 7'h01);
    if (sync_mode) begin
      odt_dly = sh_q[tap]; // [R19] [R20] [R21]
    end else begin
      odt_dly = odt_in; // [R24]
    end
  end

endmodule : odt_latency

/* File: zq_odt_host.sv */
// zq_odt_host: controller model driving commands and odt on the link clock
// assumes the bench calls its tasks and keeps the channel quiet during calibration
`timescale 1ns/1ps
module zq_odt_host
  import zq_odt_pkg::*;
(
  input wire logic ck,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic cmd_bc4,
  output logic odt
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_bc4 = 1'b0;
    odt = 1'b0;
  end
  // banks taken as precharged; single device, so no shared resistor
  // nothing sent while a window runs
  task automatic send(input cmd_t c, input logic b);
    @(posedge ck);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_bc4 <= b;
    @(posedge ck);
    cmd_valid <= 1'b0;
    // idle slot: scrambled lines, never a stale copy
    cmd_code <= ~c;
    cmd_bc4 <= ~b;
  endtask : send
  // odt only raised outside calibration, held past the hold time
  task automatic set_odt(input logic v);
    @(posedge ck);
    odt <= v;
  endtask : set_odt
endmodule : zq_odt_host

/* File: zq_odt_ctrl_bench.sv */
// zq_odt_ctrl_bench: self-checking bench for zq calibration and termination control
// assumes short calibration windows; WL=9, RL=11 at first, WL=21, RL=23 late in the run
`timescale 1ns/1ps
module zq_odt_ctrl_bench
  import zq_odt_pkg::*;
;
  logic clk = 1'b0;
  logic lck = 1'b0;
  logic srst = 1'b1;
  logic [2:0] nom = 3'h2;
  logic [2:0] park = 3'h1;
  logic [1:0] wr = 2'h1;
  logic pre2 = 1'b0;
  logic crc = 1'b0;
  logic dll = 1'b1;
  logic [4:0] cwl = 5'h09;
  logic [4:0] al = 5'h00;
  logic [2:0] pl = 3'h0;
  logic [4:0] cl = 5'h0b;
  logic cv, cb, odt, busy, cur, upd, first, sref, ign;
  logic [2:0] code, mode, rcode;
  int mismatches = 0;
  int compares = 0;
  always #5 clk = ~clk;
  always #24 lck = ~lck;
  zq_odt_host host (.ck(lck), .cmd_valid(cv), .cmd_code(code), .cmd_bc4(cb), .odt(odt));
  zq_odt_ctrl #(.ZQINIT_CYC(40), .ZQOPER_CYC(24), .ZQCS_CYC(16)) i_dut (
    .CLOCK(clk), .SRST(srst), .LINK_CK(lck), .CMD_VALID(cv), .CMD_CODE(code),
    .CMD_BC4(cb), .ODT_IN(odt), .RTT_NOM_FLD(nom), .RTT_WR_FLD(wr), .RTT_PARK_FLD(park),
    .DLL_ON(dll), .CWL(cwl), .AL(al), .PL(pl), .CL(cl), .PREAMBLE_2T(pre2),
    .WR_CRC_EN(crc), .ZQ_BUSY(busy), .ZQ_CURRENT_EN(cur), .ZQ_IO_UPDATE(upd),
    .ZQ_FIRST_DONE(first), .TERM_MODE(mode), .RTT_CODE(rcode), .IN_SELF_REFRESH(sref),
    .ODT_IGNORED(ign));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chkv(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkv
  task automatic chkn(input int got, input int exp);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkn
  task automatic tick(input int n);
    repeat (n) @(posedge lck);
    #1;
  endtask : tick
  // a loop that used up its bound ends the run as a failure
  task automatic over(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      finish_test();
    end
  endtask : over
  // bounded wait; running out ends the run
  task automatic wait_mode(input logic [2:0] m, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (mode !== m && n < 100);
    if (n >= 100) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_mode
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (48) @(posedge clk);
    #1;
    chkv(busy, 1'b0);
    chkv(first, 1'b0);
    chkv(ign, 1'b1);
    @(posedge clk);
    srst <= 1'b0;
    tick(6);
    chkv(mode, T_PARK);
    chkv(rcode, park);
  endtask : do_reset
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic zq_test(input cmd_t c, input int len);
    int n;
    int u;
    n = 0;
    u = 0;
    host.send(c, 1'b0);
    while (busy !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    over(n, 100);
    chkv(cur, 1'b1);
    chkv(mode, T_PARK);
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      u += int'(upd === 1'b1);
      n++;
      @(posedge clk);
      #1;
    end
    over(n, 2000);
    chkn(n, len);
    chkn(u, 1);
    chkv(cur, 1'b0);
    chkv(first, 1'b1);
    tick(8);
    $display("zq test done");
  endtask : zq_test
  task automatic lat_test(input logic p2, input logic d, input int exp);
    int n;
    @(posedge lck);
    pre2 <= p2;
    dll <= d;
    tick(4);
    host.set_odt(1'b1);
    wait_mode(T_NOM, n);
    chkn(n, exp);
    chkv(rcode, nom);
    tick(6);
    host.set_odt(1'b0);
    wait_mode(T_PARK, n);
    chkn(n, exp);
    $display("odt latency test done");
  endtask : lat_test
  task automatic win_test(input cmd_t c, input logic b, input logic p2, input logic y,
                          input logic [2:0] m, input logic [2:0] rc, input int d,
                          input int len);
    int n;
    @(posedge lck);
    pre2 <= p2;
    crc <= y;
    tick(4);
    host.send(c, b);
    wait_mode(m, n);
    chkn(n, d);
    chkv(rcode, rc);
    n = 0;
    while (mode === m && n < 100) begin
      n++;
      tick(1);
    end
    over(n, 100);
    chkn(n, len);
    $display("window test done");
  endtask : win_test
  task automatic sref_test();
    int n;
    @(posedge lck);
    nom <= 3'h0;
    tick(4);
    chkv(ign, 1'b1);
    host.set_odt(1'b1);
    tick(10);
    chkv(mode, T_PARK);
    @(posedge lck);
    park <= 3'h0;
    wr <= 2'h0;
    tick(4);
    chkv(mode, T_OFF);
    host.set_odt(1'b0);
    @(posedge lck);
    nom <= 3'h2;
    park <= 3'h1;
    wr <= 2'h1;
    host.send(CMD_SRE, 1'b0);
    #1;
    chkv(sref, 1'b1);
    tick(1);
    chkv(mode, T_OFF);
    chkv(ign, 1'b1);
    host.set_odt(1'b1);
    tick(10);
    chkv(mode, T_OFF);
    host.set_odt(1'b0);
    host.send(CMD_SRX, 1'b0);
    #1;
    chkv(sref, 1'b0);
    n = 0;
    repeat (20) begin
      tick(1);
      n += int'(busy === 1'b1);
    end
    chkn(n, 0);
    $display("self refresh test done");
  endtask : sref_test
  initial begin
    do_reset();
    zq_test(CMD_ZQCL, 40);
    zq_test(CMD_ZQCL, 24);
    zq_test(CMD_ZQCS, 16);
    lat_test(1'b0, 1'b0, 1);
    lat_test(1'b1, 1'b1, 7);
    lat_test(1'b0, 1'b1, 8);
    win_test(CMD_READ, 1'b0, 1'b0, 1'b0, T_DRIVE, 3'h0, 9, 6);
    win_test(CMD_WRITE, 1'b1, 1'b1, 1'b1, T_WR, 3'h1, 6, 6);
    host.set_odt(1'b1);
    tick(10);
    win_test(CMD_WRITE, 1'b0, 1'b0, 1'b0, T_WR, 3'h1, 7, 6);
    win_test(CMD_READ, 1'b1, 1'b0, 1'b0, T_DRIVE, 3'h0, 9, 4);
    host.set_odt(1'b0);
    sref_test();
    @(posedge lck);
    cwl <= 5'h0a;
    al <= 5'h0a;
    pl <= 3'h1;
    cl <= 5'h0c;
    lat_test(1'b0, 1'b1, 20);
    win_test(CMD_READ, 1'b0, 1'b0, 1'b0, T_DRIVE, 3'h0, 21, 6);
    do_reset();
    zq_test(CMD_ZQCL, 40);
    finish_test();
  end
endmodule : zq_odt_ctrl_bench
